// >>> src/cfc_fifo.sv
`timescale 1ns/10ps
module cfc_fifo #(
   parameter int DEPTH = cfc_pkg::CFC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic resetn,
   cfc_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic do_wr, do_rd;
   assign f.wr_ready = (cnt_q != (AW+1)'(DEPTH));
   assign f.rd_valid = (cnt_q != '0);
   assign f.rd_data = mem[rp_q];
   assign do_wr = f.wr_valid && f.wr_ready;
   assign do_rd = f.rd_valid && f.rd_ready;
   always_comb begin
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (f.flush) begin
         wp_d = '0;
         rp_d = '0;
         cnt_d = '0;
      end else begin
         if (do_wr) wp_d = wp_q + 1'b1;
         if (do_rd) rp_d = rp_q + 1'b1;
         cnt_d = cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end
   // storage has no reset; contents are don't-care until written
   always_ff @(posedge clk) begin
      if (do_wr && !f.flush) mem[wp_q] <= f.wr_data;
   end
endmodule // cfc_fifo

// >>> src/cfc_fifo_if.sv
`timescale 1ns/10ps
interface cfc_fifo_if;
   logic wr_valid;
   logic wr_ready;
   logic [7:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [7:0] rd_data;
   logic flush;
   modport fifo (input wr_valid, wr_data, rd_ready, flush, output wr_ready, rd_valid, rd_data);
   modport user (output wr_valid, wr_data, rd_ready, flush, input wr_ready, rd_valid, rd_data);
endinterface

// >>> src/cfc_framer.sv
`timescale 1ns/10ps
// Behaviour
// - type F sends six zero preamble bytes
// - sync word B2h then 4Dh follows
// - length byte counts payload plus itself
// - type F crc computed msb first
// - crc register starts at zero
// - preamble and sync made by hardware
// - crc appended after last payload byte
// - type F Manchester, 64 or 32 cycles
// - type B NRZ-L out, BPSK in
// - type B layers two, three in firmware
// - active: Miller 106, Manchester faster
// - passive: modified Miller out, Manchester back
// - initiator makes field, target answers
// - all modes, rates, either role; type F has no 106 rate and runs it at 212
// - one 64-byte fifo both directions
module cfc_framer (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] scheme,
   input wire logic [1:0] rate,
   input wire logic initiator,
   input wire logic tx_start,
   input wire logic rx_start,
   input wire logic fw_wr_valid,
   input wire logic [7:0] fw_wr_data,
   output logic fw_wr_ready,
   input wire logic fw_rd_ready,
   output logic fw_rd_valid,
   output logic [7:0] fw_rd_data,
   output logic tx_bit_valid,
   output logic tx_bit,
   input wire logic tx_bit_ready,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_end,
   output logic [1:0] tx_coding,
   output logic [1:0] rx_coding,
   output logic [7:0] bit_cycles,
   output logic rx_subcarrier,
   output logic rx_bpsk,
   output logic field_on,
   output logic busy,
   output logic done,
   output logic crc_error
);
   typedef enum logic [2:0] {
      CFC_IDLE = 3'h0,
      CFC_TX_HDR = 3'h1,
      CFC_TX_BODY = 3'h3,
      CFC_TX_CRC = 3'h2,
      CFC_RX_HUNT = 3'h6,
      CFC_RX_BODY = 3'h7
   } cfc_state_t;
   cfc_fifo_if fi ();
   cfc_fifo #(.DEPTH(cfc_pkg::CFC_FIFO_DEPTH)) u_fifo (.clk(clk), .resetn(resetn), .f(fi));
   cfc_state_t st_q, st_d;
   logic [7:0] sh_q, sh_d;
   logic [2:0] bit_q, bit_d;
   logic [3:0] idx_q, idx_d;
   logic [7:0] left_q, left_d;
   logic [15:0] crc_q, crc_d;
   logic [15:0] hunt_q, hunt_d;
   logic first_q, first_d;
   logic done_d, err_d, done_q, err_q;
   logic is_f;
   cfc_pkg::cfc_scheme_t sch;
   cfc_pkg::cfc_rate_t rt;
   assign sch = cfc_pkg::cfc_scheme_t'(scheme);
   assign rt = cfc_pkg::cfc_rate_t'(rate);
   assign is_f = (sch == cfc_pkg::CFC_SCH_TYPEF);
   ////////////////////////////////////////////////////////////////////////////
   // coding selection per scheme, rate and role
   always_comb begin
      tx_coding = cfc_pkg::CFC_COD_MANCH;
      rx_coding = cfc_pkg::CFC_COD_MANCH;
      rx_subcarrier = 1'b0;
      rx_bpsk = 1'b0;
      unique case (sch)
         cfc_pkg::CFC_SCH_TYPEF: tx_coding = cfc_pkg::CFC_COD_MANCH;
         cfc_pkg::CFC_SCH_TYPEB: begin
            tx_coding = cfc_pkg::CFC_COD_NRZ;
            rx_coding = cfc_pkg::CFC_COD_NRZ;
            rx_subcarrier = 1'b1;
            rx_bpsk = 1'b1;
         end
         cfc_pkg::CFC_SCH_ACT: begin
            tx_coding = (rt == cfc_pkg::CFC_RATE_106) ? cfc_pkg::CFC_COD_MILLER
                                                      : cfc_pkg::CFC_COD_MANCH;
            rx_coding = tx_coding;
         end
         cfc_pkg::CFC_SCH_PAS_INI, cfc_pkg::CFC_SCH_PAS_TGT: begin
            if (initiator) begin
               tx_coding = cfc_pkg::CFC_COD_MMILLER;
               rx_coding = cfc_pkg::CFC_COD_MANCH;
               rx_subcarrier = (rt == cfc_pkg::CFC_RATE_106);
            end else begin
               tx_coding = cfc_pkg::CFC_COD_MANCH;
               rx_coding = cfc_pkg::CFC_COD_MMILLER;
            end
         end
         default: tx_coding = cfc_pkg::CFC_COD_MANCH;
      endcase
   end
   // type F has no 106 rate; fall back to 212
   assign bit_cycles = (is_f && rt == cfc_pkg::CFC_RATE_106) ?
                       cfc_pkg::cfc_bit_cycles(cfc_pkg::CFC_RATE_212) :
                       cfc_pkg::cfc_bit_cycles(rt);
   // field: initiator always, target only in active mode and while busy sending or receiving
   assign field_on = initiator || (sch == cfc_pkg::CFC_SCH_ACT && busy);
   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer
   assign tx_bit = sh_q[7]; // msb first on the wire
   assign tx_bit_valid = (st_q == CFC_TX_HDR) || (st_q == CFC_TX_BODY) || (st_q == CFC_TX_CRC);
   assign busy = (st_q != CFC_IDLE);
   assign done = done_q;
   assign crc_error = err_q;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bit_d = bit_q;
      idx_d = idx_q;
      left_d = left_q;
      crc_d = crc_q;
      hunt_d = hunt_q;
      first_d = first_q;
      done_d = 1'b0;
      err_d = err_q;
      fi.rd_ready = 1'b0;
      fi.wr_valid = 1'b0;
      fi.wr_data = sh_q;
      fi.flush = 1'b0;
      fw_wr_ready = 1'b0;
      fw_rd_valid = 1'b0;
      fw_rd_data = fi.rd_data;
      unique case (st_q)
         CFC_IDLE: begin
            // firmware owns the fifo while idle; only length and payload go in
            fi.wr_valid = fw_wr_valid;
            fi.wr_data = fw_wr_data;
            fw_wr_ready = fi.wr_ready;
            fi.rd_ready = fw_rd_ready;
            fw_rd_valid = fi.rd_valid;
            if (tx_start && fi.rd_valid) begin
               err_d = 1'b0;
               bit_d = '0;
               crc_d = cfc_pkg::CFC_CRC_INIT;
               first_d = 1'b1;
               if (is_f) begin
                  st_d = CFC_TX_HDR;
                  idx_d = '0;
                  sh_d = cfc_pkg::CFC_PRE_BYTE;
               end else begin
                  st_d = CFC_TX_BODY;
                  sh_d = fi.rd_data;
                  fi.rd_ready = 1'b1;
               end
            end else if (rx_start) begin
               fi.flush = 1'b1;
               err_d = 1'b0;
               bit_d = '0;
               hunt_d = '0;
               first_d = 1'b1;
               crc_d = cfc_pkg::CFC_CRC_INIT;
               st_d = is_f ? CFC_RX_HUNT : CFC_RX_BODY;
            end
         end
         CFC_TX_HDR: begin
            if (tx_bit_ready) begin
               sh_d = {sh_q[6:0], 1'b0};
               bit_d = bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  idx_d = idx_q + 4'h1;
                  if (idx_q == 4'(cfc_pkg::CFC_PRE_BYTES - 1)) begin
                     sh_d = cfc_pkg::CFC_SYNC0;
                  end else if (idx_q == 4'(cfc_pkg::CFC_PRE_BYTES)) begin
                     sh_d = cfc_pkg::CFC_SYNC1;
                  end else if (idx_q == 4'(cfc_pkg::CFC_PRE_BYTES + 1)) begin
                     st_d = CFC_TX_BODY;
                     sh_d = fi.rd_data;
                     fi.rd_ready = 1'b1;
                     crc_d = cfc_pkg::cfc_crc_byte(crc_q, fi.rd_data);
                  end else begin
                     sh_d = cfc_pkg::CFC_PRE_BYTE;
                  end
               end
            end
         end
         CFC_TX_BODY: begin
            if (tx_bit_ready) begin
               sh_d = {sh_q[6:0], 1'b0};
               bit_d = bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  if (fi.rd_valid) begin
                     sh_d = fi.rd_data;
                     fi.rd_ready = 1'b1;
                     crc_d = cfc_pkg::cfc_crc_byte(crc_q, fi.rd_data);
                  end else if (is_f) begin
                     st_d = CFC_TX_CRC;
                     idx_d = '0;
                     sh_d = crc_d[15:8];
                  end else begin
                     st_d = CFC_IDLE;
                     done_d = 1'b1;
                  end
               end
            end
         end
         CFC_TX_CRC: begin
            if (tx_bit_ready) begin
               sh_d = {sh_q[6:0], 1'b0};
               bit_d = bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  idx_d = idx_q + 4'h1;
                  sh_d = crc_q[7:0];
                  if (idx_q[0]) begin
                     st_d = CFC_IDLE;
                     done_d = 1'b1;
                  end
               end
            end
         end
         CFC_RX_HUNT: begin
            // preamble and sync are dropped, never stored
            if (rx_bit_valid) begin
               hunt_d = {hunt_q[14:0], rx_bit};
               if ({hunt_q[14:0], rx_bit} == {cfc_pkg::CFC_SYNC0, cfc_pkg::CFC_SYNC1}) begin
                  st_d = CFC_RX_BODY;
                  bit_d = '0;
               end
            end
            if (rx_end) begin
               st_d = CFC_IDLE;
               err_d = 1'b1;
               done_d = 1'b1;
            end
         end
         CFC_RX_BODY: begin
            if (rx_bit_valid) begin
               sh_d = {sh_q[6:0], rx_bit};
               bit_d = bit_q + 3'h1;
               if (bit_q == 3'h7) begin
                  fi.wr_valid = 1'b1;
                  fi.wr_data = {sh_q[6:0], rx_bit};
                  first_d = 1'b0;
                  if (is_f) begin
                     crc_d = cfc_pkg::cfc_crc_byte(crc_q, {sh_q[6:0], rx_bit});
                     // length counts itself, plus two trailing crc bytes
                     left_d = first_q ? ({sh_q[6:0], rx_bit} + 8'h01) : left_q - 8'h01;
                     if (!first_q && left_q == 8'h01) begin
                        st_d = CFC_IDLE;
                        done_d = 1'b1;
                        err_d = (crc_d != 16'h0000);
                     end
                  end
                  if (!fi.wr_ready) err_d = 1'b1;
               end
            end
            if (rx_end && st_d != CFC_IDLE) begin
               st_d = CFC_IDLE;
               done_d = 1'b1;
               err_d = err_q || is_f;
            end
         end
         default: st_d = CFC_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= CFC_IDLE;
         sh_q <= '0;
         bit_q <= '0;
         idx_q <= '0;
         left_q <= '0;
         crc_q <= cfc_pkg::CFC_CRC_INIT;
         hunt_q <= '0;
         first_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         bit_q <= bit_d;
         idx_q <= idx_d;
         left_q <= left_d;
         crc_q <= crc_d;
         hunt_q <= hunt_d;
         first_q <= first_d;
         done_q <= done_d;
         err_q <= err_d;
      end
   end
endmodule // cfc_framer

// >>> src/cfc_pkg.sv
package cfc_pkg;
   // communication schemes
   typedef enum logic [2:0] {
      CFC_SCH_TYPEF = 3'h0,
      CFC_SCH_TYPEB = 3'h1,
      CFC_SCH_ACT = 3'h2,
      CFC_SCH_PAS_INI = 3'h3,
      CFC_SCH_PAS_TGT = 3'h4
   } cfc_scheme_t;
   // rates
   typedef enum logic [1:0] {
      CFC_RATE_106 = 2'h0,
      CFC_RATE_212 = 2'h1,
      CFC_RATE_424 = 2'h2
   } cfc_rate_t;
   // bit coding applied on the air
   typedef enum logic [1:0] {
      CFC_COD_NRZ = 2'h0,
      CFC_COD_MANCH = 2'h1,
      CFC_COD_MILLER = 2'h2,
      CFC_COD_MMILLER = 2'h3
   } cfc_coding_t;
   localparam int CFC_PRE_BYTES = 6;
   localparam logic [7:0] CFC_PRE_BYTE = 8'h00;
   localparam logic [7:0] CFC_SYNC0 = 8'hB2;
   localparam logic [7:0] CFC_SYNC1 = 8'h4D;
   localparam logic [15:0] CFC_CRC_INIT = 16'h0000;
   localparam logic [15:0] CFC_CRC_POLY = 16'h1021;
   localparam int CFC_CAR_106 = 128;
   localparam int CFC_CAR_212 = 64;
   localparam int CFC_CAR_424 = 32;
   localparam int CFC_SUBC_DIV = 16;
   localparam int CFC_FIFO_DEPTH = 64;
   // carrier cycles per bit for a rate
   function automatic logic [7:0] cfc_bit_cycles(input cfc_rate_t r);
      unique case (r)
         CFC_RATE_106: cfc_bit_cycles = 8'(CFC_CAR_106);
         CFC_RATE_212: cfc_bit_cycles = 8'(CFC_CAR_212);
         default: cfc_bit_cycles = 8'(CFC_CAR_424);
      endcase
   endfunction
   // crc step over one byte, msb first
   function automatic logic [15:0] cfc_crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] x;
      x = c;
      for (int i = 7; i >= 0; i--) begin
         if (x[15] ^ b[i]) begin
            x = {x[14:0], 1'b0} ^ CFC_CRC_POLY;
         end else begin
            x = {x[14:0], 1'b0};
         end
      end
      cfc_crc_byte = x;
   endfunction
endpackage

// >>> verif/cfc_framer_assertions.sv
`timescale 1ns/10ps
module cfc_framer_assertions (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [2:0] scheme,
   input wire logic [1:0] rate,
   input wire logic initiator,
   input wire logic tx_start,
   input wire logic rx_start,
   input wire logic fw_wr_ready,
   input wire logic fw_rd_valid,
   input wire logic tx_bit_valid,
   input wire logic tx_bit,
   input wire logic tx_bit_ready,
   input wire logic [1:0] tx_coding,
   input wire logic [1:0] rx_coding,
   input wire logic [7:0] bit_cycles,
   input wire logic rx_subcarrier,
   input wire logic rx_bpsk,
   input wire logic field_on,
   input wire logic busy,
   input wire logic done,
   input wire logic crc_error
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_done_pulse: assert property (done |=> !done)
      else $error("done held longer than one cycle");
   a_start_pre: assert property (!busy && tx_start && !rx_start && fw_rd_valid &&
      scheme == 3'h0 |=> tx_bit_valid && !tx_bit) else $error("frame did not open with zero");
   a_tx_hold: assert property (tx_bit_valid && !tx_bit_ready |=>
      tx_bit_valid && $stable(tx_bit)) else $error("bit dropped before ready");
   a_busy_refuse: assert property (busy |-> !fw_wr_ready && !fw_rd_valid)
      else $error("fifo open to firmware while busy");
   a_typef_code: assert property (scheme == 3'h0 |-> tx_coding == 2'h1 && rx_coding == 2'h1)
      else $error("type F coding wrong");
   a_typef_cycles: assert property (scheme == 3'h0 |-> bit_cycles == (rate == 2'h2 ? 8'h20 : 8'h40))
      else $error("type F bit period wrong");
   a_typeb_code: assert property (scheme == 3'h1 |-> tx_coding == 2'h0 && rx_bpsk && rx_subcarrier)
      else $error("type B coding wrong");
   a_other_cycles: assert property (scheme != 3'h0 |-> bit_cycles ==
      (rate == 2'h0 ? 8'h80 : rate == 2'h1 ? 8'h40 : 8'h20)) else $error("bit period wrong");
   a_active_code: assert property (scheme == 3'h2 |-> tx_coding == (rate == 2'h0 ? 2'h2 : 2'h1)
      && rx_coding == tx_coding) else $error("active coding wrong");
   a_passive_ini: assert property (scheme == 3'h3 && initiator |-> tx_coding == 2'h3
      && rx_coding == 2'h1 && rx_subcarrier == (rate == 2'h0)) else $error("passive coding wrong");
   a_field_ini: assert property (initiator |-> field_on)
      else $error("initiator without field");
   cover property (done);
   cover property ($rose(crc_error));
   cover property (tx_bit_valid && !tx_bit_ready);
endmodule // cfc_framer_assertions
bind cfc_framer cfc_framer_assertions u_chk (.clk, .resetn, .scheme, .rate, .initiator,
   .tx_start, .rx_start, .fw_wr_ready, .fw_rd_valid, .tx_bit_valid, .tx_bit, .tx_bit_ready,
   .tx_coding, .rx_coding, .bit_cycles, .rx_subcarrier, .rx_bpsk, .field_on, .busy, .done,
   .crc_error);

// >>> verif/cfc_framer_tb.sv
`timescale 1ns/10ps
module cfc_framer_tb;
   logic clk, resetn, initiator, tx_start, rx_start, fw_wr_valid, fw_rd_ready;
   logic fw_wr_ready, fw_rd_valid, tx_bit_valid, tx_bit, tx_bit_ready, rx_bit_valid, rx_bit;
   logic rx_end, rx_subcarrier, rx_bpsk, field_on, busy, done, crc_error;
   logic [2:0] scheme;
   logic [1:0] rate, tx_coding, rx_coding;
   logic [7:0] fw_wr_data, fw_rd_data, bit_cycles;
   logic seen_done = 1'b0;
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   cfc_framer u_cfc_framer (.clk, .resetn, .scheme, .rate, .initiator, .tx_start, .rx_start,
      .fw_wr_valid, .fw_wr_data, .fw_wr_ready, .fw_rd_ready, .fw_rd_valid, .fw_rd_data,
      .tx_bit_valid, .tx_bit, .tx_bit_ready, .rx_bit_valid, .rx_bit, .rx_end, .tx_coding,
      .rx_coding, .bit_cycles, .rx_subcarrier, .rx_bpsk, .field_on, .busy, .done, .crc_error);
   cfc_remote u_cfc_remote (.clk, .tx_bit_valid, .tx_bit, .tx_bit_ready, .rx_bit_valid,
      .rx_bit, .rx_end);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (done === 1'b1) seen_done <= 1'b1;
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // valid stays high across bytes so it is never driven twice in one step
   task automatic fw_load(input logic [7:0] q[$]);
      foreach (q[i]) begin
         fw_wr_valid <= 1'b1;
         fw_wr_data <= q[i];
         do @(posedge clk); while (fw_wr_ready !== 1'b1);
      end
      fw_wr_valid <= 1'b0;
   endtask
   task automatic fw_drain(input logic [7:0] q[$]);
      fw_rd_ready <= 1'b1;
      foreach (q[i]) begin
         do @(posedge clk); while (fw_rd_valid !== 1'b1);
         chk("fifo byte", fw_rd_data, q[i]);
      end
      fw_rd_ready <= 1'b0;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 3000 && seen_done !== 1'b1; i++) @(posedge clk);
      chk("done", seen_done, 1'b1);
      seen_done <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_modes();
      for (int s = 0; s < 5; s++) for (int r = 0; r < 3; r++) begin
         scheme <= 3'(s);
         rate <= 2'(r);
         initiator <= (s != 2 && s != 4);
         repeat (2) @(posedge clk);
         chk("tx coding", tx_coding, s == 1 ? 2'h0 : s == 3 ? 2'h3 : (s == 2 && r == 0) ? 2'h2 : 2'h1);
         if (s == 1) chk("bpsk", rx_bpsk, 1'b1);
         else chk("rx coding", rx_coding, s == 4 ? 2'h3 : (s == 2 && r == 0) ? 2'h2 : 2'h1);
         if (s == 3) chk("subcarrier", rx_subcarrier, r == 0);
         chk("bit cycles", bit_cycles, s == 0 ? (r == 2 ? 8'h20 : 8'h40) : (r == 0 ? 8'h80 : r == 1 ? 8'h40 : 8'h20));
         chk("field", field_on, s != 2 && s != 4);
      end
   endtask
   task automatic test_fifo();
      logic [7:0] q[$];
      for (int i = 0; i < 64; i++) q.push_back(8'(i + 16));
      scheme <= 3'h0;
      fw_load(q);
      @(posedge clk);
      chk("full", fw_wr_ready, 1'b0);
      fw_drain(q);
      @(posedge clk);
      chk("empty", fw_rd_valid, 1'b0);
   endtask
   task automatic test_tx(input logic slow, input logic [1:0] r);
      logic [7:0] e[$] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hB2, 8'h4D, 8'h03,
         8'hAB, 8'hCD, 8'h90, 8'h35};
      scheme <= 3'h0;
      rate <= r;
      u_cfc_remote.slow = slow;
      u_cfc_remote.got.delete();
      fw_load('{8'h03, 8'hAB, 8'hCD});
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      wait_done();
      chk("frame length", 8'(u_cfc_remote.got.size()), 8'h0D);
      foreach (e[i]) chk("frame byte", u_cfc_remote.got[i], e[i]);
   endtask
   task automatic test_raw();
      scheme <= 3'h1;
      u_cfc_remote.slow = 1'b0;
      u_cfc_remote.got.delete();
      fw_load('{8'h5A, 8'hC3});
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      wait_done();
      chk("raw length", 8'(u_cfc_remote.got.size()), 8'h02);
      chk("raw byte 0", u_cfc_remote.got[0], 8'h5A);
      chk("raw byte 1", u_cfc_remote.got[1], 8'hC3);
   endtask
   task automatic test_rx(input logic [7:0] last, input logic err);
      logic [7:0] f[$] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hB2, 8'h4D, 8'h03,
         8'hAB, 8'hCD, 8'h90, 8'h00};
      f[12] = last;
      scheme <= 3'h0;
      rx_start <= 1'b1;
      @(posedge clk);
      rx_start <= 1'b0;
      u_cfc_remote.send(f);
      wait_done();
      chk("crc error", crc_error, err);
      fw_drain(f[8:12]);
   endtask
   initial begin
      resetn = 1'b0;
      scheme = 3'h0;
      rate = 2'h1;
      initiator = 1'b1;
      tx_start = 1'b0;
      rx_start = 1'b0;
      fw_wr_valid = 1'b0;
      fw_wr_data = 8'h00;
      fw_rd_ready = 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk("idle after reset", busy, 1'b0);
      test_modes();
      test_fifo();
      test_tx(1'b0, 2'h1);
      test_tx(1'b1, 2'h2);
      test_raw();
      test_rx(8'h35, 1'b0);
      test_rx(8'h36, 1'b1);
      give_verdict();
   end
endmodule // cfc_framer_tb

// >>> verif/cfc_remote.sv
`timescale 1ns/10ps
module cfc_remote (
   input wire logic clk,
   input wire logic tx_bit_valid,
   input wire logic tx_bit,
   output logic tx_bit_ready,
   output logic rx_bit_valid,
   output logic rx_bit,
   output logic rx_end
);
   logic slow = 1'b0;
   logic [7:0] got[$];
   logic [7:0] sh = 8'h00;
   int nb = 0;
   int cnt = 0;
   initial begin
      tx_bit_ready = 1'b1;
      rx_bit_valid = 1'b0;
      rx_bit = 1'b0;
      rx_end = 1'b0;
   end
   // slow mode takes one bit in four so held bits get exercised
   always @(posedge clk) begin
      cnt <= cnt + 1;
      tx_bit_ready <= !slow || cnt[1:0] == 2'h3;
      if (tx_bit_valid === 1'b1 && tx_bit_ready) begin
         sh = {sh[6:0], tx_bit};
         nb = nb + 1;
         if (nb == 8) begin
            got.push_back(sh);
            nb = 0;
         end
      end
   end
   // answers only when the bench opens an exchange
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) for (int k = 7; k >= 0; k--) begin
         @(posedge clk);
         rx_bit_valid <= 1'b1;
         rx_bit <= b[i][k];
      end
      @(posedge clk);
      rx_bit_valid <= 1'b0;
      rx_bit <= ~rx_bit;
      rx_end <= 1'b1;
      @(posedge clk);
      rx_end <= 1'b0;
   endtask
endmodule // cfc_remote
